/* logic/smaf_pkg.sv */
// package for the multiprocessor address filter: register map, field layout, reset values
// assumes one 50 MHz clock domain and a plain strobed register port
package smaf_pkg;
  // register offsets
  localparam logic [7:0] SMAF_OFS_SLAVE_ADDRESS = 8'hA9;
  localparam logic [7:0] SMAF_OFS_SLAVE_MASK    = 8'hB9;
  localparam logic [7:0] SMAF_OFS_CONTROL       = 8'hC0;
  localparam logic [7:0] SMAF_OFS_STATUS        = 8'hC1;
  localparam logic [7:0] SMAF_OFS_IRQ_STATUS    = 8'hC2;
  localparam logic [7:0] SMAF_OFS_IRQ_CLEAR     = 8'hC3;
  localparam logic [7:0] SMAF_OFS_IRQ_ENABLE    = 8'hC4;
  localparam logic [7:0] SMAF_OFS_SERIAL_BUFFER = 8'h00;
  // control field positions
  localparam int SMAF_CTL_MP_EN   = 0;
  localparam int SMAF_CTL_MODE_LO = 1;
  localparam int SMAF_CTL_MODE_HI = 2;
  // status field positions
  localparam int SMAF_STS_DONE  = 0;
  localparam int SMAF_STS_NINTH = 1;
  // interrupt event positions
  localparam int SMAF_EV_ACCEPT  = 0;
  localparam int SMAF_EV_DISCARD = 1;
  localparam int SMAF_EV_NUM     = 2;
  // reset values
  localparam logic [7:0] SMAF_RST_SLAVE_ADDRESS = 8'h00;
  localparam logic [7:0] SMAF_RST_SLAVE_MASK    = 8'h00;
  localparam logic [7:0] SMAF_RST_CONTROL       = 8'h00;
  localparam logic [7:0] SMAF_RST_ZERO          = 8'h00;
  // serial port modes
  typedef enum logic [1:0] {
    SMAF_MODE_SYNC  = 2'h0,
    SMAF_MODE_TEN   = 2'h1,
    SMAF_MODE_ELEVA = 2'h2,
    SMAF_MODE_ELEVB = 2'h3
  } smaf_mode_type;
  // frame handed over by the receiver
  typedef struct packed {
    logic       done;
    logic [7:0] data;
    logic       ninth;
  } smaf_frame_type;
  // register port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } smaf_bus_type;
endpackage : smaf_pkg

/* logic/smaf_match.sv */
// masked byte comparator for given and broadcast addresses
// assumes purely combinational use inside the filter
`timescale 1ns/10ps
module smaf_match
  import smaf_pkg::*;
(
  input  wire logic [7:0] byte_in,
  input  wire logic [7:0] pattern,
  input  wire logic [7:0] care,
  output logic            hit
);
  // bits whose care bit is zero never block a match
  assign hit = ((byte_in ^ pattern) & care) == 8'h00;
endmodule : smaf_match

/* logic/smaf_irq.sv */
// sticky event bits, write-one clear, enable gate, level interrupt
// assumes events are single-cycle pulses from the filter
`timescale 1ns/10ps
module smaf_irq
  import smaf_pkg::*;
(
  input  wire logic                   clock,
  input  wire logic                   nrst,
  input  wire logic [SMAF_EV_NUM-1:0] event_in,
  input  wire logic [SMAF_EV_NUM-1:0] clear_in,
  input  wire logic                   enable_wr,
  input  wire logic [SMAF_EV_NUM-1:0] enable_in,
  output logic      [SMAF_EV_NUM-1:0] status_ff,
  output logic      [SMAF_EV_NUM-1:0] enable_ff,
  output logic                        irq_ff
);
  logic [SMAF_EV_NUM-1:0] nxt_status;
  logic [SMAF_EV_NUM-1:0] nxt_enable;
  logic                   nxt_irq;

  // set wins over a clear in the same cycle so no event is lost
  always_comb begin
    nxt_status = (status_ff & ~clear_in) | event_in;
    nxt_enable = enable_wr ? enable_in : enable_ff;
    nxt_irq    = |(nxt_status & nxt_enable);
  end

  // registered so the interrupt output comes straight from a flip-flop
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      status_ff <= '0;
      enable_ff <= '0;
      irq_ff    <= 1'b0;
    end else begin
      status_ff <= nxt_status;
      enable_ff <= nxt_enable;
      irq_ff    <= nxt_irq;
    end
  end
endmodule : smaf_irq

/* logic/smaf_filter.sv */
// multiprocessor address filter sitting behind the serial receiver
// assumes the receiver presents a completed frame as a one-cycle strobe with byte and ninth bit
//
// Implementation choice: the plain strobed port.
`timescale 1ns/10ps
// Behaviour
// - ninth bit marks address in 11-bit modes
// - enable set, mode not synchronous: accept only given/broadcast matches
// - enable set, mode not synchronous: ninth low frames never flag
// - enable clear: every complete frame flags
// - 10-bit mode: stop bit acts as ninth
// - software-writable 8-bit slave address
// - mask zero bit is don't-care in given
// - broadcast is address OR mask, zeros ignored
// - address at A9h, mask at B9h
// - both registers reset to 00h
// - accepted frame stores its ninth bit
// - load and flag only while flag clear
module smaf_filter
  import smaf_pkg::*;
(
  input  wire logic           clock,
  input  wire logic           nrst,
  input  wire smaf_bus_type   bus,
  output logic         [7:0]  rdata_ff,
  input  wire smaf_frame_type frame,
  output logic         [7:0]  serial_buffer_ff,
  output logic                receive_done_flag_ff,
  output logic                received_ninth_bit_ff,
  output logic                irq_ff
);
  logic [7:0]              slave_address_ff;
  logic [7:0]              slave_address_mask_ff;
  logic [7:0]              control_ff;
  logic [7:0]              nxt_slave_address;
  logic [7:0]              nxt_slave_address_mask;
  logic [7:0]              nxt_control;
  logic [7:0]              nxt_serial_buffer;
  logic                    nxt_done;
  logic                    nxt_ninth;
  logic [7:0]              nxt_rdata;
  logic                    given_hit;
  logic                    bcast_hit;
  logic [7:0]              bcast_pattern;
  logic                    multiproc_enable_bit;
  smaf_mode_type           mode;
  logic                    addr_marker;
  logic                    qualified;
  logic                    accept;
  logic                    discard;
  logic                    done_clear;
  logic [SMAF_EV_NUM-1:0]  ev;
  logic [SMAF_EV_NUM-1:0]  ev_clear;
  logic [SMAF_EV_NUM-1:0]  irq_status;
  logic [SMAF_EV_NUM-1:0]  irq_enable;
  logic                    wr_ctl;
  logic                    wr_clr;
  logic                    wr_en;

  assign multiproc_enable_bit = control_ff[SMAF_CTL_MP_EN];
  assign mode = smaf_mode_type'(control_ff[SMAF_CTL_MODE_HI:SMAF_CTL_MODE_LO]);
  assign bcast_pattern = slave_address_ff | slave_address_mask_ff;

  // given address: only masked-in bits are compared
  smaf_match u_given (
    .byte_in (frame.data),
    .pattern (slave_address_ff),
    .care    (slave_address_mask_ff),
    .hit     (given_hit)
  );

  // broadcast: zero bits of the OR are don't-care, so the OR is its own care mask
  smaf_match u_bcast (
    .byte_in (frame.data),
    .pattern (bcast_pattern),
    .care    (bcast_pattern),
    .hit     (bcast_hit)
  );

  // accept decision, taken in the frame-complete cycle itself
  always_comb begin
    // in 10-bit mode the receiver puts the stop bit in the ninth position
    addr_marker = frame.ninth;
    qualified   = 1'b1;
    if (multiproc_enable_bit && mode != SMAF_MODE_SYNC) begin
      // ninth low means data, which never wakes a waiting slave
      qualified = addr_marker && (given_hit || bcast_hit);
    end
    // enable clear lets every frame through
    accept  = frame.done && qualified && !receive_done_flag_ff;
    discard = frame.done && !accept;
  end

  // register port decode
  always_comb begin
    wr_ctl = bus.wr && bus.addr == SMAF_OFS_CONTROL;
    wr_clr = bus.wr && bus.addr == SMAF_OFS_IRQ_CLEAR;
    wr_en  = bus.wr && bus.addr == SMAF_OFS_IRQ_ENABLE;
    // writing a 1 to the done bit in status clears the flag
    done_clear = bus.wr && bus.addr == SMAF_OFS_STATUS && bus.wdata[SMAF_STS_DONE];
    ev = '0;
    ev[SMAF_EV_ACCEPT]  = accept;
    ev[SMAF_EV_DISCARD] = discard;
    ev_clear = wr_clr ? bus.wdata[SMAF_EV_NUM-1:0] : '0;
  end

  // next values for the address registers, control and receive state
  always_comb begin
    nxt_slave_address      = slave_address_ff;
    nxt_slave_address_mask = slave_address_mask_ff;
    nxt_control            = control_ff;
    nxt_serial_buffer      = serial_buffer_ff;
    nxt_ninth              = received_ninth_bit_ff;
    nxt_done               = receive_done_flag_ff;
    if (bus.wr && bus.addr == SMAF_OFS_SLAVE_ADDRESS) begin
      nxt_slave_address = bus.wdata;
    end
    if (bus.wr && bus.addr == SMAF_OFS_SLAVE_MASK) begin
      nxt_slave_address_mask = bus.wdata;
    end
    if (wr_ctl) begin
      nxt_control = bus.wdata & 8'h07;
    end
    if (done_clear) begin
      nxt_done = 1'b0;
    end
    // a frame that lands in the clear cycle of a set flag is discarded, since accept needs the flag already clear
    if (accept) begin
      nxt_serial_buffer = frame.data;
      nxt_ninth         = frame.ninth;
      nxt_done          = 1'b1;
    end
  end

  // read mux; unmapped offsets read as zero
  always_comb begin
    nxt_rdata = 8'h00;
    if (bus.rd) begin
      unique case (bus.addr)
        SMAF_OFS_SLAVE_ADDRESS: nxt_rdata = slave_address_ff;
        SMAF_OFS_SLAVE_MASK:    nxt_rdata = slave_address_mask_ff;
        SMAF_OFS_CONTROL:       nxt_rdata = control_ff;
        SMAF_OFS_STATUS:        nxt_rdata = {6'h00, received_ninth_bit_ff, receive_done_flag_ff};
        SMAF_OFS_IRQ_STATUS:    nxt_rdata = {6'h00, irq_status};
        SMAF_OFS_IRQ_ENABLE:    nxt_rdata = {6'h00, irq_enable};
        SMAF_OFS_SERIAL_BUFFER: nxt_rdata = serial_buffer_ff;
        default:                nxt_rdata = 8'h00;
      endcase
    end
  end

  // state registers
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      slave_address_ff      <= SMAF_RST_SLAVE_ADDRESS;
      slave_address_mask_ff <= SMAF_RST_SLAVE_MASK;
      control_ff            <= SMAF_RST_CONTROL;
      serial_buffer_ff      <= SMAF_RST_ZERO;
      received_ninth_bit_ff <= 1'b0;
      receive_done_flag_ff  <= 1'b0;
      rdata_ff              <= SMAF_RST_ZERO;
    end else begin
      slave_address_ff      <= nxt_slave_address;
      slave_address_mask_ff <= nxt_slave_address_mask;
      control_ff            <= nxt_control;
      serial_buffer_ff      <= nxt_serial_buffer;
      received_ninth_bit_ff <= nxt_ninth;
      receive_done_flag_ff  <= nxt_done;
      rdata_ff              <= nxt_rdata;
    end
  end

  // accept and discard events feed the interrupt
  smaf_irq u_irq (
    .clock     (clock),
    .nrst      (nrst),
    .event_in  (ev),
    .clear_in  (ev_clear),
    .enable_wr (wr_en),
    .enable_in (bus.wdata[SMAF_EV_NUM-1:0]),
    .status_ff (irq_status),
    .enable_ff (irq_enable),
    .irq_ff    (irq_ff)
  );

  // a filtered data frame never raises the flag
  property p_data_blocked;
    @(posedge clock) disable iff (!nrst)
      (frame.done && multiproc_enable_bit && mode != SMAF_MODE_SYNC && !frame.ninth && !receive_done_flag_ff
       && !done_clear) |=> !receive_done_flag_ff;
  endproperty
  a_data_blocked: assert property (p_data_blocked) else $error("data frame raised flag in multiproc mode");

  // with filtering off every complete frame raises the flag
  property p_open_accept;
    @(posedge clock) disable iff (!nrst)
      (frame.done && !multiproc_enable_bit && !receive_done_flag_ff) |=> receive_done_flag_ff;
  endproperty
  a_open_accept: assert property (p_open_accept) else $error("frame lost with filter off");

  // matched address frame is accepted and stored
  property p_match_accept;
    @(posedge clock) disable iff (!nrst)
      (frame.done && frame.ninth && (given_hit || bcast_hit) && !receive_done_flag_ff)
      |=> (receive_done_flag_ff && serial_buffer_ff == $past(frame.data));
  endproperty
  a_match_accept: assert property (p_match_accept) else $error("matched address not accepted");

  // a busy flag blocks the buffer load
  property p_busy_hold;
    @(posedge clock) disable iff (!nrst)
      (frame.done && receive_done_flag_ff) |=> $stable(serial_buffer_ff);
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("buffer overwritten while flag set");

  // stored ninth bit follows the accepted frame
  property p_ninth_store;
    @(posedge clock) disable iff (!nrst)
      accept |=> received_ninth_bit_ff == $past(frame.ninth);
  endproperty
  a_ninth_store: assert property (p_ninth_store) else $error("ninth bit not stored");

  // given address comparison honours the mask
  property p_given_mask;
    @(posedge clock) disable iff (!nrst)
      given_hit == ((frame.data & slave_address_mask_ff) == (slave_address_ff & slave_address_mask_ff));
  endproperty
  a_given_mask: assert property (p_given_mask) else $error("given compare wrong");

  // broadcast pattern ones must all be present in the byte
  property p_bcast;
    @(posedge clock) disable iff (!nrst)
      bcast_hit == ((frame.data & bcast_pattern) == bcast_pattern);
  endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast compare wrong");

  // address write lands in the next cycle
  property p_addr_write;
    @(posedge clock) disable iff (!nrst)
      (bus.wr && bus.addr == SMAF_OFS_SLAVE_ADDRESS) |=> slave_address_ff == $past(bus.wdata);
  endproperty
  a_addr_write: assert property (p_addr_write) else $error("slave address write lost");

  // after reset both address registers match everything
  property p_reset_open;
    @(posedge clock) disable iff (!nrst)
      $rose(nrst) |-> (slave_address_ff == 8'h00 && slave_address_mask_ff == 8'h00);
  endproperty
  a_reset_open: assert property (p_reset_open) else $error("address registers not cleared");

  // cleared address and mask leave no selectivity at all
  property p_open_match;
    @(posedge clock) disable iff (!nrst)
      (slave_address_ff == 8'h00 && slave_address_mask_ff == 8'h00) |-> (given_hit && bcast_hit);
  endproperty
  a_open_match: assert property (p_open_match) else $error("cleared registers do not match all");

  // an address that hits neither comparison is dropped while filtering
  property p_nomatch_block;
    @(posedge clock) disable iff (!nrst)
      (frame.done && multiproc_enable_bit && mode != SMAF_MODE_SYNC && !given_hit && !bcast_hit
       && !receive_done_flag_ff) |=> !receive_done_flag_ff;
  endproperty
  a_nomatch_block: assert property (p_nomatch_block) else $error("unmatched address raised flag");

  // 10-bit mode: a set stop bit with a match is accepted and stored
  property p_stop_accept;
    @(posedge clock) disable iff (!nrst)
      (frame.done && multiproc_enable_bit && mode == SMAF_MODE_TEN && frame.ninth && given_hit
       && !receive_done_flag_ff) |=> (receive_done_flag_ff && received_ninth_bit_ff);
  endproperty
  a_stop_accept: assert property (p_stop_accept) else $error("valid stop bit frame not accepted");

  // the synchronous mode has no ninth bit, so nothing is filtered there
  property p_sync_open;
    @(posedge clock) disable iff (!nrst)
      (frame.done && mode == SMAF_MODE_SYNC && !receive_done_flag_ff) |=> receive_done_flag_ff;
  endproperty
  a_sync_open: assert property (p_sync_open) else $error("synchronous frame filtered");

  // the flag rises only through an accepted frame
  property p_flag_source;
    @(posedge clock) disable iff (!nrst)
      (!receive_done_flag_ff && !accept) |=> !receive_done_flag_ff;
  endproperty
  a_flag_source: assert property (p_flag_source) else $error("flag rose without accept");

  // a raised flag waits for software
  property p_flag_stays;
    @(posedge clock) disable iff (!nrst)
      (receive_done_flag_ff && !done_clear) |=> receive_done_flag_ff;
  endproperty
  a_flag_stays: assert property (p_flag_stays) else $error("flag dropped without clear");

  // a status write with bit 0 set drops the flag
  property p_flag_clear;
    @(posedge clock) disable iff (!nrst)
      (receive_done_flag_ff && done_clear) |=> !receive_done_flag_ff;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag clear ignored");

  // the buffer changes only on an accepted frame
  property p_buffer_source;
    @(posedge clock) disable iff (!nrst)
      !accept |=> $stable(serial_buffer_ff);
  endproperty
  a_buffer_source: assert property (p_buffer_source) else $error("buffer changed without accept");

  // the stored ninth bit changes only on an accepted frame
  property p_ninth_source;
    @(posedge clock) disable iff (!nrst)
      !accept |=> $stable(received_ninth_bit_ff);
  endproperty
  a_ninth_source: assert property (p_ninth_source) else $error("ninth bit changed without accept");

  // mask write lands in the next cycle
  property p_mask_write;
    @(posedge clock) disable iff (!nrst)
      (bus.wr && bus.addr == SMAF_OFS_SLAVE_MASK) |=> slave_address_mask_ff == $past(bus.wdata);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask write lost");

  // slave address reads back one cycle after the strobe
  property p_addr_read;
    @(posedge clock) disable iff (!nrst)
      (bus.rd && bus.addr == SMAF_OFS_SLAVE_ADDRESS) |=> rdata_ff == $past(slave_address_ff);
  endproperty
  a_addr_read: assert property (p_addr_read) else $error("slave address read wrong");

  // read data stand for one cycle only, so stale values never reach software
  property p_rdata_idle;
    @(posedge clock) disable iff (!nrst)
      !bus.rd |=> rdata_ff == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero when idle");

  // every accepted frame leaves its sticky event
  property p_accept_event;
    @(posedge clock) disable iff (!nrst)
      accept |=> irq_status[SMAF_EV_ACCEPT];
  endproperty
  a_accept_event: assert property (p_accept_event) else $error("accept event lost");

  // every dropped frame leaves its sticky event, even against a clear
  property p_discard_event;
    @(posedge clock) disable iff (!nrst)
      discard |=> irq_status[SMAF_EV_DISCARD];
  endproperty
  a_discard_event: assert property (p_discard_event) else $error("discard event lost");

  // the interrupt is high exactly while an enabled event is pending
  property p_irq_level;
    @(posedge clock) disable iff (!nrst)
      irq_ff == |(irq_status & irq_enable);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");
endmodule : smaf_filter

/* verification/smaf_master_model.sv */
// remote master on the serial line, seen through the receiver: hands finished frames to the filter
// assumes one clock domain; a frame is launched by a one-cycle send request from the bench
`timescale 1ns/10ps
module smaf_master_model
  import smaf_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic       send,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_ninth,
  output smaf_frame_type  frame
);
  // frame strobe; between frames byte and ninth bit are inverted so a stale value never passes
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      frame <= '0;
    end else if (send) begin
      frame <= '{done: 1'b1, data: tx_data, ninth: tx_ninth};
    end else begin
      frame <= '{done: 1'b0, data: ~frame.data, ninth: ~frame.ninth};
    end
  end
endmodule : smaf_master_model

/* verification/smaf_filter_tb_top.sv */
// self-checking bench for the multiprocessor address filter
// assumes the register map of smaf_pkg and the master model on the frame input
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin error_cnt++; \
  $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end
module smaf_filter_tb_top import smaf_pkg::*;;
  logic           clock;
  logic           nrst;
  smaf_bus_type   bus;
  logic [7:0]     rdata_ff;
  smaf_frame_type frame;
  logic [7:0]     serial_buffer_ff;
  logic           receive_done_flag_ff;
  logic           received_ninth_bit_ff;
  logic           irq_ff;
  logic           send;
  logic [7:0]     tx_data;
  logic           tx_ninth;
  int             error_cnt;
  int             total_checks;

  smaf_filter i_dut (.clock(clock), .nrst(nrst), .bus(bus), .rdata_ff(rdata_ff), .frame(frame),
    .serial_buffer_ff(serial_buffer_ff), .receive_done_flag_ff(receive_done_flag_ff),
    .received_ninth_bit_ff(received_ninth_bit_ff), .irq_ff(irq_ff));
  smaf_master_model i_master (.clock(clock), .nrst(nrst), .send(send), .tx_data(tx_data),
    .tx_ninth(tx_ninth), .frame(frame));

  // clock, 20 ns period
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock);
    bus <= '0;
    @(posedge clock);
  endtask : reg_wr

  // read data stand only in the cycle after the strobe, so sample there
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string nm);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock);
    bus <= '0;
    #1 `CHK(nm, exp, rdata_ff)
    @(posedge clock);
  endtask : rd_chk

  // four edges after launch: model strobe, filter take with irq, then two spare edges
  task automatic frame_chk(input logic [7:0] d, input logic n, input logic f, input logic [7:0] b);
    send     <= 1'b1;
    tx_data  <= d;
    tx_ninth <= n;
    @(posedge clock);
    send <= 1'b0;
    repeat (3) @(posedge clock);
    `CHK("flag", f, receive_done_flag_ff)
    `CHK("buffer", b, serial_buffer_ff)
  endtask : frame_chk

  task automatic conclude;
    if (error_cnt == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude

  // watchdog, far beyond the roughly 120 cycles the sequence needs
  initial begin
    #100000;
    error_cnt++;
    conclude();
  end

  initial begin
    nrst = 1'b0; bus = '0; send = 1'b0; tx_data = 8'h00; tx_ninth = 1'b0;
    error_cnt = 0; total_checks = 0;
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    rd_chk(8'hA9, 8'h00, "addr_rst");
    rd_chk(8'hB9, 8'h00, "mask_rst");
    rd_chk(8'h77, 8'h00, "unmapped");
    reg_wr(8'hA9, 8'hA4);
    reg_wr(8'hB9, 8'hFA);
    rd_chk(8'hA9, 8'hA4, "addr");
    rd_chk(8'hB9, 8'hFA, "mask");
    reg_wr(8'hC0, 8'h07);  // filtering on, 11-bit mode
    frame_chk(8'hA5, 1'b0, 1'b0, 8'h00);
    rd_chk(8'hC2, 8'h02, "irq_discard");
    `CHK("irq_masked", 1'b0, irq_ff)
    reg_wr(8'hC4, 8'h03);
    @(posedge clock);
    `CHK("irq_on", 1'b1, irq_ff)
    reg_wr(8'hC3, 8'h03);
    @(posedge clock);
    `CHK("irq_cleared", 1'b0, irq_ff)
    frame_chk(8'hA2, 1'b1, 1'b0, 8'h00);
    reg_wr(8'hC3, 8'h02);  // drop the discard event so only the accept can raise the interrupt
    frame_chk(8'hA5, 1'b1, 1'b1, 8'hA5);
    `CHK("ninth", 1'b1, received_ninth_bit_ff)
    `CHK("irq_accept", 1'b1, irq_ff)
    rd_chk(8'hC2, 8'h01, "irq_accept_sts");
    rd_chk(8'hC4, 8'h03, "irq_en");
    rd_chk(8'hC3, 8'h00, "irq_clr_rd");
    rd_chk(8'hC0, 8'h07, "ctl");
    rd_chk(8'hC1, 8'h03, "status");
    frame_chk(8'hA1, 1'b1, 1'b1, 8'hA5);
    reg_wr(8'hC1, 8'h01);
    frame_chk(8'hFE, 1'b1, 1'b1, 8'hFE);
    reg_wr(8'hC1, 8'h01);
    reg_wr(8'hC0, 8'h03);  // filtering on, 10-bit mode
    frame_chk(8'hA4, 1'b0, 1'b0, 8'hFE);
    frame_chk(8'hA4, 1'b1, 1'b1, 8'hA4);
    reg_wr(8'hC1, 8'h01);
    reg_wr(8'hC0, 8'h06);  // filtering off
    frame_chk(8'h12, 1'b0, 1'b1, 8'h12);
    `CHK("ninth_low", 1'b0, received_ninth_bit_ff)
    reg_wr(8'hC1, 8'h01);
    reg_wr(8'hC0, 8'h01);  // enable set, synchronous mode: no ninth bit to filter on
    frame_chk(8'h55, 1'b0, 1'b1, 8'h55);
    reg_wr(8'hC1, 8'h01);
    reg_wr(8'hC0, 8'h05);  // filtering on, first 11-bit mode
    frame_chk(8'h70, 1'b1, 1'b0, 8'h55);
    frame_chk(8'hFF, 1'b1, 1'b1, 8'hFF);
    rd_chk(8'h00, 8'hFF, "buffer_rd");
    // second reset: cleared address and mask make every byte a match
    nrst <= 1'b0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    rd_chk(8'hA9, 8'h00, "addr_rst2");
    rd_chk(8'hB9, 8'h00, "mask_rst2");
    reg_wr(8'hC0, 8'h07);
    frame_chk(8'h3C, 1'b1, 1'b1, 8'h3C);
    conclude();
  end
endmodule : smaf_filter_tb_top
